// file: include/udw_pkg.sv
// shared constants and types for the wiper counter host controller
package udw_pkg;
    localparam int unsigned SYS_CLK_MHZ = 200;
    // timing figures in ns, chosen plainly, no device values given
    localparam int unsigned STEP_HALF_NS   = 1000;
    localparam int unsigned SELECT_SETUP_NS = 1000;
    localparam int unsigned SAVE_WAIT_NS   = 20000;
    localparam int unsigned CLK_PERIOD_NS  = 1000 / SYS_CLK_MHZ;
    localparam int unsigned STEP_HALF_CYC  = (STEP_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC      = (SELECT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAVE_CYC       = (SAVE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W        = 16;
    localparam int unsigned POS_W          = 7;
    localparam logic [POS_W-1:0] POS_MAX   = 7'h63;
    localparam logic [POS_W-1:0] POS_MIN   = 7'h00;

    typedef enum logic { UDW_DIR_DOWN, UDW_DIR_UP } udw_dir_e;

    // request from the user side
    typedef struct packed {
        logic             go;
        udw_dir_e         dir;
        logic [POS_W-1:0] steps;
        logic             save;
    } udw_req_s;

    // pins driven to the potentiometer
    typedef struct packed {
        logic select_n;
        logic step_n;
        logic dir_up;
    } udw_pins_s;
endpackage

// file: rtl/udw_timer.sv
// down-counting interval timer with one-cycle done pulse
`timescale 1ns/100ps
module udw_timer
    import udw_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic               load,
    input  wire logic [TIMER_W-1:0] count,
    output logic                    done
);
    logic [TIMER_W-1:0] cnt_reg;
    logic [TIMER_W-1:0] cnt_next;
    logic               run_reg;
    logic               run_next;
    logic               done_reg;
    logic               done_next;

    always_comb begin
        cnt_next  = cnt_reg;
        run_next  = run_reg;
        done_next = 1'b0;
        if (load) begin
            cnt_next = count;
            run_next = 1'b1;
        end else if (run_reg) begin
            if (cnt_reg <= 16'h0001) begin
                run_next  = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg  <= 16'h0000;
            run_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            run_reg  <= run_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;
endmodule

// file: rtl/udw_host.sv
// host controller driving select, step and direction of the wiper counter
// Rules of the wiper counter this block drives
// [RULE1] device moves only on step falling edge; the bench model also steps when select falls with step low
// [RULE2] each selected falling step moves one
// [RULE3] device decodes count to one tap
// [RULE4] direction high steps up, low down
// [RULE5] device ignores step while unselected
// [RULE6] device count saturates at both ends
// [RULE7] raise select, step high: save position
// [RULE8] raise select, step low: no save
// [RULE9] device enters standby after save
// [RULE10] device recalls saved count at power-up
// [RULE11] direction may change while selected
// [RULE12] device taps make before break
// [RULE13] never lower select with step low
// [RULE14] up moves toward high terminal
// [RULE15] position spans 0 to 99
`timescale 1ns/100ps
module udw_host
    import udw_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire udw_req_s         req,
    input  wire logic [POS_W-1:0] recalled_pos,
    input  wire logic             recalled_valid,
    output udw_pins_s             pins,
    output logic                  busy,
    output logic                  done,
    output logic [POS_W-1:0]      pos_est
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_DESEL, ST_SAVE_WAIT
    } udw_state_e;

    udw_state_e       state_reg, state_next;
    udw_pins_s        pins_reg, pins_next;
    logic [POS_W-1:0] left_reg, left_next;
    logic             save_reg, save_next;
    logic [POS_W-1:0] pos_reg, pos_next;
    logic             busy_reg, busy_next;
    logic             done_reg, done_next;
    logic             tload;
    logic [TIMER_W-1:0] tcount;
    logic             tdone;
    logic             rec_valid_s1, rec_valid_s2;
    logic [POS_W-1:0] rec_pos_s1, rec_pos_s2;

    // mirror of the device's saturating count
    function automatic logic [POS_W-1:0] step_pos(
        input logic [POS_W-1:0] p,
        input udw_dir_e         d
    );
        if (d == UDW_DIR_UP)
            step_pos = (p >= POS_MAX) ? POS_MAX : p + 7'h01;
        else
            step_pos = (p == POS_MIN) ? POS_MIN : p - 7'h01;
    endfunction

    udw_timer u_timer (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .load    (tload),
        .count   (tcount),
        .done    (tdone)
    );

    // recalled position arrives from outside the clock domain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rec_valid_s1 <= 1'b0;
            rec_valid_s2 <= 1'b0;
            rec_pos_s1   <= 7'h00;
            rec_pos_s2   <= 7'h00;
        end else begin
            rec_valid_s1 <= recalled_valid;
            rec_valid_s2 <= rec_valid_s1;
            rec_pos_s1   <= recalled_pos;
            rec_pos_s2   <= rec_pos_s1;
        end
    end

    always_comb begin
        state_next = state_reg;
        pins_next  = pins_reg;
        left_next  = left_reg;
        save_next  = save_reg;
        pos_next   = pos_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        tload      = 1'b0;
        tcount     = 16'h0000;
        unique case (state_reg)
            ST_IDLE: begin
                // [RULE10] track recalled position
                if (rec_valid_s2)
                    pos_next = (rec_pos_s2 > POS_MAX) ? POS_MAX : rec_pos_s2;
                if (req.go && req.steps == 7'h00 && !req.save) begin
                    // [RULE8] nothing to move or store
                    // select stays high: a no-store exit here would drop step as select rises
                    busy_next  = 1'b1;
                    tload      = 1'b1;
                    tcount     = TIMER_W'(SETUP_CYC);
                    state_next = ST_SAVE_WAIT;
                end else if (req.go) begin
                    // [RULE13] step high before select falls
                    pins_next.step_n   = 1'b1;
                    // [RULE4] [RULE11] direction set while idle
                    pins_next.dir_up   = (req.dir == UDW_DIR_UP);
                    pins_next.select_n = 1'b0;
                    left_next  = req.steps;
                    save_next  = req.save;
                    busy_next  = 1'b1;
                    tload      = 1'b1;
                    tcount     = TIMER_W'(SETUP_CYC);
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP, ST_HIGH: begin
                if (tdone) begin
                    if (left_reg != 7'h00) begin
                        // [RULE1] falling edge makes one step
                        pins_next.step_n = 1'b0;
                        // [RULE6] saturating mirror of count
                        pos_next   = step_pos(pos_reg,
                                     pins_reg.dir_up ? UDW_DIR_UP : UDW_DIR_DOWN);
                        left_next  = left_reg - 7'h01;
                        tload      = 1'b1;
                        tcount     = TIMER_W'(STEP_HALF_CYC);
                        state_next = ST_LOW;
                    end else begin
                        state_next = ST_DESEL;
                    end
                end
            end
            ST_LOW: begin
                if (tdone) begin
                    // [RULE7] keep step high when save wanted
                    if (left_reg == 7'h00 && !save_reg) begin
                        pins_next.step_n = 1'b0;
                    end else begin
                        pins_next.step_n = 1'b1;
                    end
                    tload      = 1'b1;
                    tcount     = TIMER_W'(STEP_HALF_CYC);
                    state_next = ST_HIGH;
                end
            end
            ST_DESEL: begin
                // [RULE8] select rises with step at save choice
                pins_next.step_n   = save_reg;
                pins_next.select_n = 1'b1;
                tload      = 1'b1;
                tcount     = save_reg ? TIMER_W'(SAVE_CYC) : TIMER_W'(SETUP_CYC);
                state_next = ST_SAVE_WAIT;
            end
            ST_SAVE_WAIT: begin
                // [RULE9] wait out the store before next select
                if (tdone) begin
                    pins_next.step_n = 1'b1;
                    busy_next  = 1'b0;
                    done_next  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            pins_reg  <= '{select_n: 1'b1, step_n: 1'b1, dir_up: 1'b0};
            left_reg  <= 7'h00;
            save_reg  <= 1'b0;
            pos_reg   <= POS_MIN;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            pins_reg  <= pins_next;
            left_reg  <= left_next;
            save_reg  <= save_next;
            pos_reg   <= pos_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign pins    = pins_reg;
    assign busy    = busy_reg;
    assign done    = done_reg;
    assign pos_est = pos_reg;

    // step falls only while selected
    step_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE5]
        $fell(pins.step_n) |-> !pins.select_n)
        else $error("step fell while unselected");

    // select never falls with step low
    sel_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE13]
        $fell(pins.select_n) |-> pins.step_n)
        else $error("select fell with step low");

    // save request raises select with step high
    save_seq_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE7]
        ($rose(pins.select_n) && save_reg) |-> pins.step_n)
        else $error("save without step high");

    // no-save raises select with step low
    nosave_seq_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE8]
        ($rose(pins.select_n) && !save_reg) |-> !pins.step_n)
        else $error("no-save with step high");

    // direction stable across a falling step
    dir_stable_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE4]
        $fell(pins.step_n) |-> $stable(pins.dir_up))
        else $error("direction changed at step edge");

    // estimate stays within 0..99
    pos_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE15]
        pos_est <= POS_MAX)
        else $error("position estimate out of range");

    // one step per falling edge, saturating
    pos_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE6]
        (state_reg != ST_LOW && state_next == ST_LOW) |=>
        pos_est == step_pos($past(pos_est), pins.dir_up ? UDW_DIR_UP : UDW_DIR_DOWN))
        else $error("position mirror wrong");

    // done pulse rises in the cycle busy falls and lasts one cycle
    done_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [RULE9]
        $rose(done) |-> $fell(busy) && pins.select_n ##1 !done)
        else $error("done pulse malformed");
endmodule

// file: testbench/udw_pot_model.sv
// behavioural model of the potentiometer control section
`timescale 1ns/100ps
module udw_pot_model
    import udw_pkg::*;
#(
    parameter logic [POS_W-1:0] NVM_INIT = 7'h61,
    // settling time of the old tap in ns, a plain value
    parameter int unsigned STEP_TO_WIPER_NS = 500
)(
    input  wire logic        power_good,
    input  wire udw_pins_s   pins,
    output logic [POS_W-1:0] wiper_pos,
    output logic [POS_W-1:0] nvm_pos,
    output logic [POS_W-1:0] recall_pos,
    output logic             recall_valid,
    output logic             standby,
    output logic [99:0]      tap_sel
);
    logic [POS_W-1:0] settled_pos;
    initial begin
        nvm_pos      = NVM_INIT;
        settled_pos  = 7'h00;
        wiper_pos    = 7'h00;
        recall_pos   = 7'h00;
        recall_valid = 1'b0;
        standby      = 1'b1;
    end
    // old tap stays made while the new one settles
    always @(wiper_pos) settled_pos <= #(STEP_TO_WIPER_NS) wiper_pos;
    // one tap per count once settled
    assign tap_sel = (100'h1 << wiper_pos) | (100'h1 << settled_pos);
    task automatic step_once();
        if (pins.dir_up && wiper_pos < POS_MAX)
            wiper_pos = wiper_pos + 7'h01;
        else if (!pins.dir_up && wiper_pos > POS_MIN)
            wiper_pos = wiper_pos - 7'h01;
    endtask
    always @(posedge power_good) begin
        wiper_pos    = nvm_pos;
        recall_pos   = nvm_pos;
        recall_valid = 1'b1;
        // short flag, a standing level would keep reloading the host mirror
        #100 recall_valid = 1'b0;
    end
    always @(negedge pins.step_n) begin
        if (pins.select_n === 1'b0)
            step_once();
    end
    always @(negedge pins.select_n) begin
        standby = 1'b0;
        if (pins.step_n === 1'b0)
            step_once();
    end
    always @(posedge pins.select_n) begin
        if (!standby && pins.step_n === 1'b1)
            nvm_pos = wiper_pos;
        standby = 1'b1;
    end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the wiper counter host controller
`timescale 1ns/100ps
module testbench;
    import udw_pkg::*;
    localparam logic [POS_W-1:0] NVM_INIT = 7'h61;
    logic             sys_clk;
    logic             sys_rst;
    logic             power_good;
    udw_req_s         req;
    udw_pins_s        pins;
    logic             busy;
    logic             done;
    logic             recall_valid;
    logic             standby;
    logic [POS_W-1:0] pos_est;
    logic [POS_W-1:0] wiper_pos;
    logic [POS_W-1:0] nvm_pos;
    logic [POS_W-1:0] recall_pos;
    logic [POS_W-1:0] exp_pos;
    logic [POS_W-1:0] exp_nvm;
    logic [99:0]      tap_sel;
    int               num_errors;
    int               check_count;

    udw_host dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .recalled_pos(recall_pos),
        .recalled_valid(recall_valid), .pins(pins), .busy(busy), .done(done), .pos_est(pos_est));
    udw_pot_model #(.NVM_INIT(NVM_INIT)) pot (.power_good(power_good), .pins(pins),
        .wiper_pos(wiper_pos), .nvm_pos(nvm_pos), .recall_pos(recall_pos),
        .recall_valid(recall_valid), .standby(standby), .tap_sel(tap_sel));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check_pos(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp,
                             input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s is %0d, expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s is %b, expected %b", $time, what, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [POS_W-1:0] moved(input logic [POS_W-1:0] p, input logic up,
                                              input logic [POS_W-1:0] n);
        logic [POS_W-1:0] r;
        r = p;
        for (int i = 0; i < int'(n); i++) begin
            if (up && r < POS_MAX)
                r = r + 7'h01;
            else if (!up && r > POS_MIN)
                r = r - 7'h01;
        end
        return r;
    endfunction

    // one selection; poke fires a go while busy, which must be ignored
    task automatic run_sel(input udw_dir_e dir, input logic [POS_W-1:0] steps,
                           input logic save, input logic poke);
        @(posedge sys_clk);
        req <= '{go: 1'b1, dir: dir, steps: steps, save: save};
        @(posedge sys_clk);
        req.go <= 1'b0;
        @(posedge sys_clk);
        if (poke)
            req <= '{go: 1'b1, dir: UDW_DIR_UP, steps: 7'h32, save: 1'b1};
        #1;
        check_bit(busy, 1'b1, "busy");
        check_bit(pins.select_n, (steps == 7'h00 && !save), "select");
        @(posedge sys_clk);
        req.go <= 1'b0;
        for (int i = 0; i < 60000 && done !== 1'b1; i++)
            @(posedge sys_clk);
        check_bit(done, 1'b1, "done");
        repeat (3) @(posedge sys_clk);
        #1;
        check_bit(busy, 1'b0, "busy after done");
        check_bit(pins.step_n, 1'b1, "idle strobe");
        exp_pos = moved(exp_pos, dir == UDW_DIR_UP, steps);
        if (save)
            exp_nvm = exp_pos;
        check_pos(wiper_pos, exp_pos, "wiper");
        check_pos(pos_est, exp_pos, "mirror");
        check_pos(nvm_pos, exp_nvm, "stored");
        check_bit(tap_sel[exp_pos], 1'b1, "tap");
        check_bit($onehot(tap_sel), 1'b1, "single tap");
        check_bit(standby, 1'b1, "standby");
    endtask

    task automatic t_reset();
        #1;
        check_bit(pins.select_n, 1'b1, "select in reset");
        check_pos(pos_est, POS_MIN, "mirror in reset");
    endtask
    task automatic t_recall();
        power_good <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        exp_pos = NVM_INIT;
        exp_nvm = NVM_INIT;
        check_pos(pos_est, exp_pos, "recalled mirror");
        check_pos(wiper_pos, exp_pos, "recalled wiper");
        repeat (24) @(posedge sys_clk);
    endtask
    task automatic t_up_top();
        run_sel(UDW_DIR_UP, 7'h04, 1'b0, 1'b0);
    endtask
    task automatic t_down_save();
        run_sel(UDW_DIR_DOWN, 7'h03, 1'b1, 1'b1);
    endtask
    task automatic t_zero();
        run_sel(UDW_DIR_UP, 7'h00, 1'b0, 1'b0);
    endtask
    task automatic t_bottom();
        run_sel(UDW_DIR_DOWN, 7'h62, 1'b0, 1'b0);
    endtask

    initial begin
        sys_rst = 1'b1;
        power_good = 1'b0;
        req = '0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_recall();
        t_up_top();
        t_down_save();
        t_zero();
        t_bottom();
        test_done();
    end
    // whole run is near 50000 cycles
    initial begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end
endmodule
